// file: verilog/dldc_pkg.sv
// Package: constants, types and register map of the line direction control
package dldc_pkg;
	localparam int CLK_HZ = 25_000_000;
	localparam int CLK_NS = 40;
	localparam int DRV_DELAY_NS = 2000;
	localparam int DRV_DELAY_CYC = (DRV_DELAY_NS + CLK_NS - 1) / CLK_NS;
	localparam int BAUD_REF = 9600;
	localparam logic [15:0] BIT_DIV_RST = 16'(CLK_HZ / BAUD_REF);
	localparam logic [3:0] CHAR_BITS = 4'hA;
	localparam logic LINE_MARK = 1'h1;
	localparam int APB_AW = 8;

	localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h00;
	localparam logic [APB_AW-1:0] ADDR_STAT = 8'h04;
	localparam logic [APB_AW-1:0] ADDR_IRQ_STAT = 8'h08;
	localparam logic [APB_AW-1:0] ADDR_IRQ_MASK = 8'h0C;
	localparam logic [APB_AW-1:0] ADDR_BIT_DIV = 8'h10;

	localparam int STAT_DRV = 0;
	localparam int STAT_CTS = 1;
	localparam int STAT_TRANSMITTER_FULLY_EMPTY = 2;
	localparam int STAT_TMR = 3;
	localparam int STAT_RTS = 4;
	localparam int STAT_RXD = 5;

	localparam int EV_DRV_ON = 0;
	localparam int EV_DRV_OFF = 1;
	localparam int EV_FALSE_START = 2;
	localparam int EV_CHAR_TIME = 3;
	localparam int EV_TRANSMITTER_FULLY_EMPTY = 4;
	localparam int EV_W = 5;

	typedef enum logic [1:0] {DLDC_P2P, DLDC_MULTI, DLDC_HALF} dldc_mode_e;
	localparam logic [1:0] MODE_BAD = 2'h3;

	typedef struct packed {
		logic rts;
		logic txd;
		logic holding_register_empty_event;
		logic transmitter_fully_empty;
	} dldc_uart_s;

	typedef struct packed {
		dldc_mode_e mode;
		logic [EV_W-1:0] mask;
		logic [EV_W-1:0] stat;
		logic [15:0] div;
		logic [2:0] sync_sh;
		logic [2:0] sync_rx;
		logic st_sh;
		logic st_rx;
		logic drv;
		logic cts;
		logic tx_o;
		logic rxd;
		logic irq;
		logic transmitter_fully_empty_d;
		logic tmr_on;
		logic [15:0] tmr_cyc;
		logic [3:0] tmr_bits;
		logic [7:0] rts_run;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} dldc_top_s;

	localparam dldc_top_s TOP_RST = '{mode: DLDC_HALF, mask: 5'h00, stat: 5'h00,
		div: BIT_DIV_RST, sync_sh: 3'h7, sync_rx: 3'h7, st_sh: 1'h1, st_rx: 1'h1,
		drv: 1'h0, cts: 1'h0, tx_o: LINE_MARK, rxd: 1'h1, irq: 1'h0, transmitter_fully_empty_d: 1'h0,
		tmr_on: 1'h0, tmr_cyc: 16'h0000, tmr_bits: 4'h0, rts_run: 8'h00,
		pready: 1'h0, pslverr: 1'h0, prdata: 32'h00000000};
endpackage : dldc_pkg

// file: verilog/dldc_delay.sv
// Isolation delay: output follows the input once it has held for CYC cycles
`timescale 1ns/100ps
module dldc_delay #(
	parameter int CYC = dldc_pkg::DRV_DELAY_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic din,
	output logic dout
);
	localparam int CW = $clog2(CYC + 1);
	typedef struct packed {
		logic [CW-1:0] cnt;
		logic out;
	} dldc_dly_s;
	dldc_dly_s s;
	dldc_dly_s n;

	if (CYC < 1) begin : g_chk
		$error("dldc_delay: CYC must be at least 1");
	end

	always_comb begin
		n = s;
		if (din == s.out) begin
			n.cnt = '0;
		end else if (s.cnt == CW'(CYC - 1)) begin
			n.out = din;
			n.cnt = '0;
		end else begin
			n.cnt = s.cnt + CW'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign dout = s.out;

	a_dly_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(din != s.out) && (s.cnt != CW'(CYC - 1)) |=> $stable(s.out))
		else $error("delay output moved before the delay ran out");
endmodule : dldc_delay

// file: verilog/dldc_glitch.sv
// Receive filter: a level must hold len cycles to pass; short start pulses dropped
`timescale 1ns/100ps
module dldc_glitch (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic din,
	input wire logic [15:0] len,
	output logic dout,
	output logic reject
);
	typedef struct packed {
		logic [15:0] cnt;
		logic out;
		logic rej;
	} dldc_flt_s;
	dldc_flt_s s;
	dldc_flt_s n;

	always_comb begin
		n = s;
		n.rej = 1'h0;
		if (din == s.out) begin
			n.rej = (s.cnt != 16'h0000) & s.out;
			n.cnt = 16'h0000;
		end else if ({1'h0, s.cnt} + 17'h00001 >= {1'h0, len}) begin
			n.out = din;
			n.cnt = 16'h0000;
		end else begin
			n.cnt = s.cnt + 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '{cnt: 16'h0000, out: 1'h1, rej: 1'h0};
		end else begin
			s <= n;
		end
	end

	assign dout = s.out;
	assign reject = s.rej;

	a_glitch_hold: assert property (@(posedge pclk) disable iff (!presetn)
		s.out && !din && ({1'h0, s.cnt} + 17'h00001 < {1'h0, len}) |=> s.out)
		else $error("short low pulse reached the receiver");
endmodule : dldc_glitch

// file: verilog/dldc_top.sv
// Transmit direction control for an isolated differential serial channel
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/100ps
// Behaviour
// - Three modes: full-duplex point-to-point, full-duplex multi-drop, half-duplex shared pair.
// - Half-duplex receives on shared pair; full-duplex modes receive on separate pair.
// - Multi-drop and half-duplex: driver enabled by request-to-send, off when inactive.
// - Driver turns on about two microseconds after request-to-send rises, except in point-to-point, where it stays on.
// - Clear-to-send is request-to-send delayed by the same driver delay.
// - Holding-register-empty to fully-empty takes about one character time.
// - Receiver rejects false start bits so driver-enable glitches give no character.
// - With no transmitter active, the pair idles in the no-character state.
module dldc_top #(
	parameter int DLY_CYC = dldc_pkg::DRV_DELAY_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [dldc_pkg::APB_AW-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire dldc_pkg::dldc_uart_s uart_in,
	output logic uart_cts,
	output logic uart_rxd,
	input wire logic port_a_shared_pair_i,
	output logic port_a_shared_pair_o,
	output logic port_a_shared_pair_oe,
	input wire logic rx_pair_i,
	output logic irq
);
	dldc_pkg::dldc_top_s s;
	dldc_pkg::dldc_top_s n;
	logic rts_dly;
	logic filt_in;
	logic filt_out;
	logic filt_rej;
	logic [15:0] filt_len;
	logic [dldc_pkg::EV_W-1:0] ev;
	logic [dldc_pkg::EV_W-1:0] clr;
	logic [31:0] rd;
	logic hit;
	logic acc;

	if (DLY_CYC < 1 || DLY_CYC > 250) begin : g_chk
		$error("dldc_top: DLY_CYC must lie in 1..250");
	end

	function automatic logic [15:0] eff_div(input logic [15:0] d);
		return (d == 16'h0000) ? 16'h0001 : d;
	endfunction : eff_div

	// Receive source follows the mode
	assign filt_in = (s.mode == dldc_pkg::DLDC_HALF) ? s.st_sh : s.st_rx;
	// Half a bit period must pass before a start edge counts
	assign filt_len = eff_div({1'h0, s.div[15:1]});

	dldc_delay #(
		.CYC(DLY_CYC)
	) u_delay (
		.pclk(pclk),
		.presetn(presetn),
		.din(uart_in.rts),
		.dout(rts_dly)
	);

	dldc_glitch u_glitch (
		.pclk(pclk),
		.presetn(presetn),
		.din(filt_in),
		.len(filt_len),
		.dout(filt_out),
		.reject(filt_rej)
	);

	always_comb begin
		n = s;
		ev = '0;
		clr = '0;
		rd = 32'h00000000;
		hit = 1'h1;
		acc = psel & penable;

		// Pin synchronisers, a change counts once the last two agree
		n.sync_sh = {s.sync_sh[1:0], port_a_shared_pair_i};
		n.sync_rx = {s.sync_rx[1:0], rx_pair_i};
		if (s.sync_sh[1] == s.sync_sh[2]) begin
			n.st_sh = s.sync_sh[2];
		end
		if (s.sync_rx[1] == s.sync_rx[2]) begin
			n.st_rx = s.sync_rx[2];
		end

		// Line driver and matched clear-to-send
		if (s.mode == dldc_pkg::DLDC_P2P) begin
			n.drv = 1'h1;
		end else begin
			n.drv = rts_dly;
		end
		n.cts = rts_dly;
		n.tx_o = n.drv ? uart_in.txd : dldc_pkg::LINE_MARK;
		n.rxd = filt_out;
		if (!uart_in.rts) begin
			n.rts_run = 8'h00;
		end else if (s.rts_run != 8'hFF) begin
			n.rts_run = s.rts_run + 8'h01;
		end

		ev[dldc_pkg::EV_DRV_ON] = n.drv & ~s.drv;
		ev[dldc_pkg::EV_DRV_OFF] = ~n.drv & s.drv;
		ev[dldc_pkg::EV_FALSE_START] = filt_rej;
		n.transmitter_fully_empty_d = uart_in.transmitter_fully_empty;
		ev[dldc_pkg::EV_TRANSMITTER_FULLY_EMPTY] = uart_in.transmitter_fully_empty & ~s.transmitter_fully_empty_d;

		// One character time from holding-register-empty
		if (uart_in.holding_register_empty_event) begin
			n.tmr_on = 1'h1;
			n.tmr_cyc = 16'h0000;
			n.tmr_bits = 4'h0;
		end else if (s.tmr_on) begin
			if (s.tmr_cyc >= eff_div(s.div) - 16'h0001) begin
				n.tmr_cyc = 16'h0000;
				if (s.tmr_bits >= dldc_pkg::CHAR_BITS - 4'h1) begin
					n.tmr_on = 1'h0;
					ev[dldc_pkg::EV_CHAR_TIME] = 1'h1;
				end else begin
					n.tmr_bits = s.tmr_bits + 4'h1;
				end
			end else begin
				n.tmr_cyc = s.tmr_cyc + 16'h0001;
			end
		end

		// Register read word
		if (paddr == dldc_pkg::ADDR_CTRL) begin
			rd[1:0] = s.mode;
		end else if (paddr == dldc_pkg::ADDR_STAT) begin
			rd[dldc_pkg::STAT_DRV] = s.drv;
			rd[dldc_pkg::STAT_CTS] = s.cts;
			rd[dldc_pkg::STAT_TRANSMITTER_FULLY_EMPTY] = s.transmitter_fully_empty_d;
			rd[dldc_pkg::STAT_TMR] = s.tmr_on;
			rd[dldc_pkg::STAT_RTS] = s.rts_run != 8'h00;
			rd[dldc_pkg::STAT_RXD] = s.rxd;
		end else if (paddr == dldc_pkg::ADDR_IRQ_STAT) begin
			rd[dldc_pkg::EV_W-1:0] = s.stat;
		end else if (paddr == dldc_pkg::ADDR_IRQ_MASK) begin
			rd[dldc_pkg::EV_W-1:0] = s.mask;
		end else if (paddr == dldc_pkg::ADDR_BIT_DIV) begin
			rd[15:0] = s.div;
		end else begin
			hit = 1'h0;
		end

		// One wait state, then completion
		n.pready = acc & ~s.pready;
		n.pslverr = 1'h0;
		if (acc & ~s.pready) begin
			n.pslverr = ~hit;
			n.prdata = pwrite ? 32'h00000000 : rd;
		end

		// Writes land at the completing edge
		if (acc & s.pready & pwrite) begin
			if (paddr == dldc_pkg::ADDR_CTRL) begin
				if (pwdata[1:0] != dldc_pkg::MODE_BAD) begin
					n.mode = dldc_pkg::dldc_mode_e'(pwdata[1:0]);
				end
			end else if (paddr == dldc_pkg::ADDR_IRQ_STAT) begin
				clr = pwdata[dldc_pkg::EV_W-1:0];
			end else if (paddr == dldc_pkg::ADDR_IRQ_MASK) begin
				n.mask = pwdata[dldc_pkg::EV_W-1:0];
			end else if (paddr == dldc_pkg::ADDR_BIT_DIV) begin
				n.div = pwdata[15:0];
			end
		end

		// New event wins over a clear in the same cycle
		n.stat = (s.stat & ~clr) | ev;
		n.irq = |(n.stat & n.mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= dldc_pkg::TOP_RST;
		end else begin
			s <= n;
		end
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign uart_cts = s.cts;
	assign uart_rxd = s.rxd;
	assign port_a_shared_pair_o = s.tx_o;
	assign port_a_shared_pair_oe = s.drv;
	assign irq = s.irq;

	a_drv_on_time: assert property (@(posedge pclk) disable iff (!presetn)
		(s.mode != dldc_pkg::DLDC_P2P) && (s.rts_run == 8'(DLY_CYC + 1))
		|-> port_a_shared_pair_oe)
		else $error("driver not on one delay after request-to-send");

	a_cts_match: assert property (@(posedge pclk) disable iff (!presetn)
		(s.mode != dldc_pkg::DLDC_P2P) && $stable(s.mode)
		|-> uart_cts == port_a_shared_pair_oe)
		else $error("clear-to-send and driver enable disagree");

	a_p2p_drive: assert property (@(posedge pclk) disable iff (!presetn)
		s.mode == dldc_pkg::DLDC_P2P
		|=> port_a_shared_pair_oe && (port_a_shared_pair_o == $past(uart_in.txd)))
		else $error("point-to-point driver not following transmit data");

	a_idle_mark: assert property (@(posedge pclk) disable iff (!presetn)
		!port_a_shared_pair_oe |-> port_a_shared_pair_o == dldc_pkg::LINE_MARK)
		else $error("idle pair not at mark");

	a_rx_source: assert property (@(posedge pclk) disable iff (!presetn)
		filt_in == ((s.mode == dldc_pkg::DLDC_HALF) ? s.st_sh : s.st_rx))
		else $error("receiver listening on the wrong pair");

	a_char_time: assert property (@(posedge pclk) disable iff (!presetn)
		uart_in.holding_register_empty_event && (s.div == 16'h0001)
		##1 (!uart_in.holding_register_empty_event && s.div == 16'h0001) [*8]
		##1 (!uart_in.holding_register_empty_event && s.div == 16'h0001) [*2]
		|=> s.stat[dldc_pkg::EV_CHAR_TIME])
		else $error("character timer did not expire after ten bits");

	a_event_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		filt_rej |=> s.stat[dldc_pkg::EV_FALSE_START])
		else $error("rejected start bit not recorded");

	a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
		irq == |(s.stat & s.mask))
		else $error("interrupt output not matching masked status");
endmodule : dldc_top

// file: verif/dldc_remote.sv
// Remote station model on the shared pair and the separate receive pair
`timescale 1ns/100ps
module dldc_remote (
	input wire logic pclk,
	input wire logic oe,
	input wire logic o,
	output logic shared_i,
	output logic rx_i
);
	logic en = 1'h0;
	logic v = 1'h1;
	// Released pair is pulled to mark by the idle bias
	assign shared_i = oe ? o : (en ? v : 1'h1);
	assign rx_i = en ? v : 1'h1;
	// Drives only when commanded; the shared pair only while the local driver is off
	task automatic hold(input logic lvl, input int n);
		@(posedge pclk);
		en <= 1'h1;
		v <= lvl;
		repeat (n) @(posedge pclk);
		en <= 1'h0;
	endtask : hold
endmodule : dldc_remote

// file: verif/dldc_top_tb_top.sv
// Self-checking bench for the line direction control
`timescale 1ns/100ps
module dldc_top_tb_top;
	localparam int DLY = 3;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready, pslverr, cts, rxd, sh_i, rx_i, pair_o, oe, irq;
	dldc_pkg::dldc_uart_s u = '{rts: 1'h0, txd: 1'h1, default: 1'h0};
	int error_cnt = 0;
	int n_compared = 0;
	logic [31:0] r;
	logic e;
	always #20 pclk = ~pclk;
	dldc_top #(.DLY_CYC(DLY)) dldc_top_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .uart_in(u), .uart_cts(cts), .uart_rxd(rxd),
		.port_a_shared_pair_i(sh_i), .port_a_shared_pair_o(pair_o),
		.port_a_shared_pair_oe(oe), .rx_pair_i(rx_i), .irq(irq));
	dldc_remote dldc_remote_inst (.pclk(pclk), .oe(oe), .o(pair_o), .shared_i(sh_i),
		.rx_i(rx_i));
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		n_compared++;
		if (g !== x) begin
			error_cnt++;
			$display("ERROR %0t: got %h expected %h", $time, g, x);
		end
	endtask : chk
	function automatic logic unmapped(input logic [7:0] a);
		return !(a == dldc_pkg::ADDR_CTRL || a == dldc_pkg::ADDR_STAT ||
			a == dldc_pkg::ADDR_IRQ_STAT || a == dldc_pkg::ADDR_IRQ_MASK ||
			a == dldc_pkg::ADDR_BIT_DIV);
	endfunction : unmapped
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// Request held until pready is seen at a rising edge
		do begin
			@(posedge pclk);
		end while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		chk(e, unmapped(a));
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic rdc(input logic [7:0] a, input logic [31:0] x);
		apb(1'h0, a, 32'h00000000);
		chk(r, x);
	endtask : rdc
	task automatic drive_on(input logic [1:0] m);
		logic b;
		apb(1'h1, dldc_pkg::ADDR_CTRL, {30'h0, m});
		@(posedge pclk);
		u.rts <= 1'h1;
		repeat (DLY + 1) @(negedge pclk);
		chk(oe, m == 2'h0);
		chk(cts, 1'h0);
		@(negedge pclk);
		chk(oe, 1'h1);
		chk(cts, 1'h1);
		repeat (8) begin
			b = $urandom % 2;
			@(posedge pclk);
			u.txd <= b;
			@(posedge pclk);
			@(negedge pclk);
			chk(pair_o, b);
		end
		@(posedge pclk);
		u.txd <= 1'h1;
		u.transmitter_fully_empty <= 1'h1;
		@(posedge pclk);
		u.rts <= 1'h0;
		u.transmitter_fully_empty <= 1'h0;
		repeat (DLY + 1) @(negedge pclk);
		chk(oe, 1'h1);
		@(negedge pclk);
		chk(oe, m == 2'h0);
		chk(cts, 1'h0);
		chk(pair_o, 1'h1);
		$display("driver test mode %0d done", m);
	endtask : drive_on
	task automatic rx_test(input logic [1:0] m);
		apb(1'h1, dldc_pkg::ADDR_CTRL, {30'h0, m});
		apb(1'h1, dldc_pkg::ADDR_IRQ_STAT, 32'h0000001F);
		dldc_remote_inst.hold(1'h0, 2);
		repeat (12) @(negedge pclk);
		chk(rxd, 1'h1);
		rdc(dldc_pkg::ADDR_IRQ_STAT, 32'h00000004);
		dldc_remote_inst.hold(1'h0, 20);
		chk(rxd, 1'h0);
		dldc_remote_inst.hold(1'h1, 20);
		chk(rxd, 1'h1);
		$display("receive test mode %0d done", m);
	endtask : rx_test
	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		stop_test();
	end
	initial begin
		void'($urandom(2893));
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		rdc(dldc_pkg::ADDR_CTRL, 32'h00000002);
		rdc(dldc_pkg::ADDR_STAT, 32'h00000020);
		rdc(dldc_pkg::ADDR_IRQ_MASK, 32'h00000000);
		rdc(dldc_pkg::ADDR_BIT_DIV, 32'h00000A2C);
		rdc(8'h14, 32'h00000000);
		chk(e, 1'h1);
		apb(1'h1, dldc_pkg::ADDR_CTRL, 32'h00000003);
		rdc(dldc_pkg::ADDR_CTRL, 32'h00000002);
		$display("register test done");
		for (int m = 0; m < 3; m++)
			drive_on(m);
		@(posedge pclk);
		u.rts <= 1'h1;
		repeat (1 + $urandom % (DLY - 1)) @(posedge pclk);
		u.rts <= 1'h0;
		repeat (8) begin
			@(negedge pclk);
			chk(oe, 1'h0);
		end
		apb(1'h1, dldc_pkg::ADDR_BIT_DIV, 32'h00000008);
		rx_test(2'h2);
		rx_test(2'h0);
		apb(1'h1, dldc_pkg::ADDR_BIT_DIV, 32'h00000001);
		apb(1'h1, dldc_pkg::ADDR_CTRL, 32'h00000002);
		apb(1'h1, dldc_pkg::ADDR_IRQ_STAT, 32'h0000001F);
		apb(1'h1, dldc_pkg::ADDR_IRQ_MASK, 32'h00000008);
		@(posedge pclk);
		u.holding_register_empty_event <= 1'h1;
		@(posedge pclk);
		u.holding_register_empty_event <= 1'h0;
		repeat (8) @(negedge pclk);
		chk(irq, 1'h0);
		repeat (6) @(negedge pclk);
		chk(irq, 1'h1);
		apb(1'h1, dldc_pkg::ADDR_IRQ_STAT, 32'h00000008);
		@(negedge pclk);
		chk(irq, 1'h0);
		apb(1'h1, dldc_pkg::ADDR_IRQ_MASK, 32'h00000010);
		u.transmitter_fully_empty <= 1'h1;
		repeat (3) @(negedge pclk);
		chk(irq, 1'h1);
		rdc(dldc_pkg::ADDR_IRQ_STAT, 32'h00000010);
		rdc(dldc_pkg::ADDR_STAT, 32'h00000024);
		apb(1'h1, dldc_pkg::ADDR_IRQ_MASK, 32'h00000000);
		repeat (2) @(negedge pclk);
		chk(irq, 1'h0);
		$display("timer and interrupt test done");
		stop_test();
	end
endmodule : dldc_top_tb_top
